// File: src/mpd_cfg.svh
// Purpose: constants for the memory partition decoder
// Assumes: 64 kB program and data spaces, 1 kB data SRAM
// Notes:   sizes are in 1 kB units unless stated
`ifndef MPD_CFG_SVH
`define MPD_CFG_SVH
`define MPD_SRAM_TOP       16'h03FF
`define MPD_DFLASH_BASE    16'h0400
`define MPD_FLASH_KB       6'h20
`define MPD_PART_RESET     3'h7
`define MPD_DIRECT_TOP     8'h7F
`define MPD_BITRAM_BASE    8'h20
`define MPD_BITRAM_TOP     8'h2F
`define MPD_BIT_SFR_BASE   8'h80
`define MPD_CFGA_RESET     8'hFF
`define MPD_CFGB_RESET     8'hFF
`define MPD_EXT_ENABLE_MSK 8'h03
`define MPD_PART_LSB       0
`endif

// File: src/mpd_pkg.sv
// Purpose: types for the memory partition decoder
// Assumes: included constants from mpd_cfg.svh
// Notes:   targets are one-hot free binary codes
package mpd_pkg;
  // ==========================================================
  // access targets
  typedef enum logic [2:0]
  {
    MPD_TGT_NONE    = 3'h0,
    MPD_TGT_PFLASH  = 3'h1,
    MPD_TGT_DFLASH  = 3'h2,
    MPD_TGT_SRAM    = 3'h3,
    MPD_TGT_SCRATCH = 3'h4,
    MPD_TGT_SFR     = 3'h5,
    MPD_TGT_EXT     = 3'h6
  } mpd_target_t;

  // ==========================================================
  // access kinds coming from the core
  typedef enum logic [2:0]
  {
    MPD_ACC_FETCH   = 3'h0,
    MPD_ACC_CODERD  = 3'h1,
    MPD_ACC_DATA    = 3'h2,
    MPD_ACC_DIRECT  = 3'h3,
    MPD_ACC_INDIR   = 3'h4,
    MPD_ACC_BIT     = 3'h5
  } mpd_kind_t;

  typedef struct packed
  {
    logic        valid;
    mpd_kind_t   kind;
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mpd_req_t;

  typedef struct packed
  {
    logic        valid;
    mpd_target_t target;
    logic [15:0] addr;
    logic        write;
    logic [7:0]  wdata;
    logic        bit_op;
    logic [2:0]  bit_sel;
    logic        blocked;
    logic        port_data_zero;
  } mpd_route_t;

  typedef struct packed
  {
    logic [7:0]  cfg_a;
    logic [7:0]  cfg_b;
    mpd_route_t  route;
  } mpd_state_t;
endpackage : mpd_pkg

// File: src/mpd_decoder.sv
// Purpose: steer core accesses to flash, SRAM, scratchpad, SPECIAL_FUNCTION_REGISTER or ext port
// Assumes: one request per cycle, registered routing answer next cycle
// Notes:   config registers load only while programming mode is high
//
// Function
// - program and data are separate 64 kB spaces from zero to FFFF
// - on-chip range goes internal when enabled, else external port
// - 3-bit partition code splits flash between program and data
// - program flash shrinks from top; fetches above go external, or are blocked with ports off
// - zero kB program flash sends every fetch external, or blocks it with ports off
// - data flash sits above SRAM starting at 0400 hex
// - data 0000 to 03FF is SRAM, flash follows above it
// - provide 1024 bytes of data SRAM via data-space move
// - internal data accesses show zero on the address/data port when the external port is enabled
// - two config registers writable only in programming mode
// - data flash, and program flash with ports off, readable by data move; writes gated by write select
// - never fetch instructions from data flash region
// - protection bit blocks program flash writes through data move only
// - code-read instruction reads program space; fetches automatic
// - direct register addresses 00 to 7F select scratchpad
// - direct register addresses 80 to FF select SFRs
// - upper scratchpad only indirect; direct goes to SFRs
// - scratchpad 20 to 2F bit addressable, bit op by kind
// - SFRs ending in hex 0 or 8 support bit access
// - unimplemented SPECIAL_FUNCTION_REGISTER reads return zero, except while sfr_erase is high
`timescale 1ns/10ps
`include "mpd_cfg.svh"

module mpd_decoder
#(
  parameter logic [5:0] FLASH_KB = `MPD_FLASH_KB
)
(
  input  wire logic            ref_clk,
  input  wire logic            reset_n,
  input  wire mpd_pkg::mpd_req_t req,
  input  wire logic            prog_mode,
  input  wire logic            cfg_a_we,
  input  wire logic            cfg_b_we,
  input  wire logic [7:0]      cfg_wdata,
  input  wire logic            flash_move_write_enable,
  input  wire logic            pflash_protect,
  input  wire logic            sfr_implemented,
  input  wire logic            sfr_erase,
  output logic [7:0]           hw_config_reg_a,
  output logic [7:0]           hw_config_reg_b,
  output mpd_pkg::mpd_route_t  route,
  output logic                 sfr_read_zero
);

  // ==========================================================
  // partition helpers
  // program flash size in kB for a partition code
  function automatic logic [5:0] prog_kb(input logic [2:0] sel);
    logic [5:0] d;
    d = data_kb(sel);
    prog_kb = FLASH_KB - d;
  endfunction : prog_kb

  // data flash size in kB, scaled to the fitted part size
  function automatic logic [5:0] data_kb(input logic [2:0] sel);
    logic [5:0] d;
    d = 6'h00;
    unique case (sel)
      3'h0, 3'h1: d = FLASH_KB;
      3'h2: d = (FLASH_KB > 6'h10) ? 6'h10 : FLASH_KB;
      3'h3: d = (FLASH_KB > 6'h08) ? 6'h08 : FLASH_KB;
      3'h4: d = (FLASH_KB > 6'h04) ? 6'h04 : FLASH_KB;
      3'h5: d = 6'h02;
      3'h6: d = 6'h01;
      3'h7: d = 6'h00;
    endcase
    data_kb = d;
  endfunction : data_kb

  // top-exclusive byte limit from a kB count
  function automatic logic [16:0] kb_limit(input logic [5:0] kb);
    kb_limit = {1'b0, kb, 10'h000};
  endfunction : kb_limit

  mpd_pkg::mpd_state_t state_reg;
  mpd_pkg::mpd_state_t state_next;

  logic [2:0]  part_sel;
  logic        ext_enabled;
  logic [16:0] prog_lim;
  logic [16:0] data_lim;
  logic [16:0] addr_x;

  // ==========================================================
  // partition decode
  // config is static outside programming, so this is safe combinational
  assign part_sel    = state_reg.cfg_a[`MPD_PART_LSB +: 3];
  // ports enabled when both low bits of config b are clear
  assign ext_enabled = (state_reg.cfg_b & `MPD_EXT_ENABLE_MSK) == 8'h00;
  assign prog_lim    = kb_limit(prog_kb(part_sel));
  assign data_lim    = {1'b0, `MPD_DFLASH_BASE}
                       + kb_limit(data_kb(part_sel));
  assign addr_x      = {1'b0, req.addr};

  // ==========================================================
  // next-state logic
  always_comb
  begin
    state_next = state_reg;
    state_next.route.valid          = 1'b0;
    state_next.route.target         = mpd_pkg::MPD_TGT_NONE;
    state_next.route.addr           = req.addr;
    state_next.route.write          = req.write;
    state_next.route.wdata          = req.wdata;
    state_next.route.bit_op         = 1'b0;
    state_next.route.bit_sel        = req.addr[2:0];
    state_next.route.blocked        = 1'b0;
    state_next.route.port_data_zero = 1'b0;

    // config load only in programming mode
    if (prog_mode && cfg_a_we)
    begin
      state_next.cfg_a = cfg_wdata;
    end
    if (prog_mode && cfg_b_we)
    begin
      state_next.cfg_b = cfg_wdata;
    end

    if (req.valid)
    begin
      state_next.route.valid = 1'b1;
      unique case (req.kind)
        mpd_pkg::MPD_ACC_FETCH, mpd_pkg::MPD_ACC_CODERD:
        begin
          // program space: fetch or code-read share one map
          if (addr_x < prog_lim)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_PFLASH;
          end
          else if (ext_enabled)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_EXT;
          end
          else
          begin
            state_next.route.blocked = 1'b1;
          end
          state_next.route.write = 1'b0;
        end
        mpd_pkg::MPD_ACC_DATA:
        begin
          if (req.addr <= `MPD_SRAM_TOP)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_SRAM;
          end
          else if (addr_x < data_lim)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_DFLASH;
            state_next.route.blocked =
              req.write && !flash_move_write_enable;
          end
          else if ((addr_x - {1'b0, `MPD_DFLASH_BASE}) <
                   kb_limit(FLASH_KB) && !ext_enabled)
          begin
            // program flash read through data move
            state_next.route.target = mpd_pkg::MPD_TGT_PFLASH;
            state_next.route.addr   = req.addr - `MPD_DFLASH_BASE;
            state_next.route.blocked = req.write &&
              (!flash_move_write_enable || pflash_protect);
          end
          else if (ext_enabled)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_EXT;
          end
          else
          begin
            state_next.route.blocked = 1'b1;
          end
          // internal hits keep port data at zero while the external port is enabled
          state_next.route.port_data_zero = ext_enabled &&
            (state_next.route.target != mpd_pkg::MPD_TGT_EXT);
        end
        mpd_pkg::MPD_ACC_DIRECT:
        begin
          // direct upper half never reaches scratchpad
          if (req.addr[7:0] <= `MPD_DIRECT_TOP)
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_SCRATCH;
          end
          else
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_SFR;
          end
          state_next.route.addr = {8'h00, req.addr[7:0]};
        end
        mpd_pkg::MPD_ACC_INDIR:
        begin
          state_next.route.target = mpd_pkg::MPD_TGT_SCRATCH;
          state_next.route.addr   = {8'h00, req.addr[7:0]};
        end
        mpd_pkg::MPD_ACC_BIT:
        begin
          // bit address: 00-7F into 20-2F bytes, 80-FF into SPECIAL_FUNCTION_REGISTER x0/x8
          state_next.route.bit_op = 1'b1;
          if (!req.addr[7])
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_SCRATCH;
            state_next.route.addr   =
              {8'h00, `MPD_BITRAM_BASE | {4'h0, req.addr[6:3]}};
          end
          else
          begin
            state_next.route.target = mpd_pkg::MPD_TGT_SFR;
            state_next.route.addr   =
              {8'h00, req.addr[7:3], 3'h0};
          end
        end
        default:
        begin
          state_next.route.blocked = 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg.cfg_a <= `MPD_CFGA_RESET;
      state_reg.cfg_b <= `MPD_CFGB_RESET;
      state_reg.route <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign hw_config_reg_a = state_reg.cfg_a;
  assign hw_config_reg_b = state_reg.cfg_b;
  assign route           = state_reg.route;
  // read of absent SPECIAL_FUNCTION_REGISTER returns zero; erase input unused beyond gating
  assign sfr_read_zero   = state_reg.route.valid && !sfr_erase &&
                           (state_reg.route.target == mpd_pkg::MPD_TGT_SFR)
                           && !sfr_implemented;

endmodule : mpd_decoder

// File: verif/mpd_core_model.sv
// Purpose: core-side request source for mpd_decoder
// Assumes: a request is taken on the edge after it is driven
// Notes:   idle cycles invert the address so stale values never match
`timescale 1ns/10ps
module mpd_core_model
(
  input  wire logic         ref_clk,
  output mpd_pkg::mpd_req_t req
);
  // =====
  // one request, held across its taking edge
  initial req = '0;
  task automatic issue(input logic [2:0] k, input logic w,
                       input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 req = '{1'b1, mpd_pkg::mpd_kind_t'(k), w, a, d};
    @(posedge ref_clk);
    #1 req = '{1'b0, mpd_pkg::mpd_kind_t'(k), 1'b0, ~a, ~d};
  endtask : issue
endmodule : mpd_core_model

// File: verif/mpd_decoder_asserts.sv
// Purpose: port checks for mpd_decoder
// Assumes: answer one cycle after a taken request
// Notes:   kind 7 is unused, so it marks an idle cycle
`timescale 1ns/10ps
module mpd_decoder_asserts #(parameter logic [5:0] FLASH_KB = 6'h20)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire mpd_pkg::mpd_req_t req,
  input wire logic prog_mode,
  input wire logic cfg_a_we,
  input wire logic cfg_b_we,
  input wire logic [7:0] cfg_wdata,
  input wire logic flash_move_write_enable,
  input wire logic pflash_protect,
  input wire logic sfr_implemented,
  input wire logic sfr_erase,
  input wire logic [7:0] hw_config_reg_a,
  input wire logic [7:0] hw_config_reg_b,
  input wire mpd_pkg::mpd_route_t route,
  input wire logic sfr_read_zero
);
  // =====
  // qualifiers shared by the checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire logic       ext_on = hw_config_reg_b[1:0] == 2'h0;
  wire logic [2:0] code = hw_config_reg_a[2:0];
  wire logic [2:0] k = req.valid ? req.kind : 3'h7;
  wire logic [2:0] t = route.target;
  // routing checks, one cycle after the taking edge
  chk_answer_next: assert property (req.valid |=> route.valid)
    else $error("no answer");
  chk_cfg_locked: assert property (!prog_mode |=>
    $stable(hw_config_reg_a) && $stable(hw_config_reg_b)) else $error("cfg");
  chk_sram_low: assert property (k == 3'h2 && req.addr <= 16'h03FF
    |=> t == 3'h3) else $error("sram");
  chk_no_pm_fetch: assert property (k == 3'h0 && code <= 3'h1 && ext_on
    |=> t == 3'h6) else $error("fetch ext");
  chk_fetch_not_df: assert property (k == 3'h0 |=> t != 3'h2)
    else $error("fetch dflash");
  chk_split_top: assert property (k == 3'h0 && code == 3'h6 && ext_on
    && FLASH_KB == 6'h20 && req.addr >= 16'h7C00 |=> t == 3'h6) else $error("split");
  chk_direct_sfr: assert property (k == 3'h3 |=> t == {2'h2, $past(req.addr[7])})
    else $error("direct");
  chk_bit_ram: assert property (k == 3'h5 && !req.addr[7] |=> t == 3'h4
    && route.bit_op && route.bit_sel == $past(req.addr[2:0])) else $error("bit");
  chk_sfr_zero: assert property (route.valid && t == 3'h5 && !route.write
    && !sfr_implemented && !sfr_erase |-> sfr_read_zero) else $error("zero");
  cover property (k == 3'h0 ##1 t == 3'h6);
  cover property (route.bit_op);
  cover property (sfr_read_zero);
  cover property (route.valid && route.blocked);
endmodule : mpd_decoder_asserts

// File: verif/tb_mpd_decoder.sv
// Purpose: self-checking bench for mpd_decoder
// Assumes: 10 MHz clock; inputs move 1 ns after the rising edge
// Notes:   kind and target codes are the package enum values
`timescale 1ns/10ps
module tb_mpd_decoder;
  logic ref_clk, reset_n, prog_mode, cfg_a_we, cfg_b_we, sfr_erase;
  logic flash_move_write_enable, pflash_protect, sfr_implemented;
  logic [7:0] cfg_wdata, hw_config_reg_a, hw_config_reg_b;
  logic sfr_read_zero;
  mpd_pkg::mpd_req_t   req;
  mpd_pkg::mpd_route_t route;
  int n_errors = 0, total_checks = 0, cycles = 0;
  // =====
  // core model and decoder
  mpd_core_model u_mpd_core_model (.ref_clk, .req);
  mpd_decoder u_mpd_decoder (.ref_clk, .reset_n, .req, .prog_mode,
    .cfg_a_we, .cfg_b_we, .cfg_wdata, .flash_move_write_enable,
    .pflash_protect, .sfr_implemented, .sfr_erase, .hw_config_reg_a,
    .hw_config_reg_b, .route, .sfr_read_zero);
  // clock; the guard is about forty times the expected run
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cycles == 3000)
      final_report(1'b1);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    n_errors += (seen !== exp);
    if (seen !== exp)
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask : check
  task automatic final_report(input logic hung);
    n_errors += hung;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // read of kind k at a; the answer must be valid and go to target t
  task automatic acc(input logic [2:0] k, input logic [15:0] a,
                     input logic [2:0] t);
    u_mpd_core_model.issue(k, 1'b0, a, 8'h00);
    check({12'h000, route.valid, route.target}, {12'h001, t});
  endtask : acc
  // config load: a on one edge, b on the next, under mode pm
  task automatic wcfg(input logic pm, input logic [7:0] a, input logic [7:0] b);
    @(posedge ref_clk);
    #1 {prog_mode, cfg_a_we, cfg_wdata} = {pm, 1'b1, a};
    @(posedge ref_clk);
    #1 {cfg_a_we, cfg_b_we, cfg_wdata} = {2'b01, b};
    @(posedge ref_clk);
    #1 {prog_mode, cfg_b_we} = 2'b00;
  endtask : wcfg
  // reset map: code 111 and ports off, so program flash shows through
  // data move at addr-0400 and a fetch past 32 kB has nowhere to go
  task automatic t_default();
    acc(3'h0, 16'h7FFF, 3'h1);
    acc(3'h0, 16'h8000, 3'h0);
    check(16'(route.blocked), 16'h0001);
    acc(3'h2, 16'h0401, 3'h1);
    check(route.addr, 16'h0001);
    check(16'(route.port_data_zero), 16'h0000);
    {flash_move_write_enable, pflash_protect} = 2'b11;
    u_mpd_core_model.issue(3'h2, 1'b1, 16'h0402, 8'h3C);
    check(16'(route.blocked), 16'h0001);
    pflash_protect = 1'b0;
    u_mpd_core_model.issue(3'h2, 1'b1, 16'h0402, 8'h3C);
    check(16'(route.blocked), 16'h0000);
    check(16'({route.write, route.wdata}), 16'h013C);
    {flash_move_write_enable, pflash_protect} = 2'b00;
    $display("t_default end");
  endtask : t_default
  // loads outside programming mode must be ignored
  task automatic t_config();
    check({hw_config_reg_a, hw_config_reg_b}, 16'hFFFF);
    wcfg(1'b0, 8'h00, 8'h00);
    check({hw_config_reg_a, hw_config_reg_b}, 16'hFFFF);
    wcfg(1'b1, 8'h06, 8'hFC);
    check({hw_config_reg_a, hw_config_reg_b}, 16'h06FC);
    $display("t_config end");
  endtask : t_config
  // split 110 then 000 with the external port on; write gating
  task automatic t_data();
    acc(3'h0, 16'h7BFF, 3'h1);
    acc(3'h0, 16'h7C00, 3'h6);
    acc(3'h0, 16'h0400, 3'h1);
    acc(3'h1, 16'h0100, 3'h1);
    acc(3'h2, 16'h0000, 3'h3);
    check(16'(route.port_data_zero), 16'h0001);
    acc(3'h2, 16'h03FF, 3'h3);
    acc(3'h2, 16'h0400, 3'h2);
    acc(3'h2, 16'h07FF, 3'h2);
    acc(3'h2, 16'h0800, 3'h6);
    u_mpd_core_model.issue(3'h2, 1'b1, 16'h0400, 8'hA5);
    check(16'(route.blocked), 16'h0001);
    {flash_move_write_enable, pflash_protect} = 2'b11;
    u_mpd_core_model.issue(3'h2, 1'b1, 16'h0401, 8'h5A);
    check(16'(route.blocked), 16'h0000);
    wcfg(1'b1, 8'h00, 8'hFC);
    acc(3'h0, 16'h0000, 3'h6);
    acc(3'h2, 16'h83FF, 3'h2);
    acc(3'h2, 16'h8400, 3'h6);
    $display("t_data end");
  endtask : t_data
  // register space: direct, indirect and bit forms
  task automatic t_regs();
    acc(3'h3, 16'h007F, 3'h4);
    acc(3'h3, 16'h0080, 3'h5);
    check(16'(sfr_read_zero), 16'h0001);
    // a present register must not read as zero; output is combinational
    sfr_implemented = 1'b1;
    #1 check(16'(sfr_read_zero), 16'h0000);
    acc(3'h4, 16'h0080, 3'h4);
    acc(3'h5, 16'h0005, 3'h4);
    check(16'({route.bit_op, route.bit_sel}), 16'h000D);
    check(route.addr, 16'h0020);
    acc(3'h5, 16'h007F, 3'h4);
    check(route.addr, 16'h002F);
    acc(3'h5, 16'h0088, 3'h5);
    check(16'(route.bit_op), 16'h0001);
    check(route.addr, 16'h0088);
    acc(3'h5, 16'h008D, 3'h5);
    check(route.addr, 16'h0088);
    $display("t_regs end");
  endtask : t_regs
  // reset in mid-run: config and route fall back to their reset values
  task automatic t_reset();
    reset_n = 1'b0;
    #1 check({hw_config_reg_a, hw_config_reg_b}, 16'hFFFF);
    check(16'(route.valid), 16'h0000);
    @(posedge ref_clk);
    #1 reset_n = 1'b1;
    acc(3'h0, 16'h7FFF, 3'h1);
    $display("t_reset end");
  endtask : t_reset
  // reset for 8 cycles, then the scenarios
  initial
  begin
    {ref_clk, reset_n, prog_mode, cfg_a_we, cfg_b_we, sfr_erase} = 6'h00;
    {flash_move_write_enable, pflash_protect, sfr_implemented} = 3'h0;
    cfg_wdata = 8'h00;
    repeat (8) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    t_default();
    t_config();
    t_data();
    t_regs();
    t_reset();
    final_report(1'b0);
  end
endmodule : tb_mpd_decoder
bind mpd_decoder mpd_decoder_asserts #(.FLASH_KB(FLASH_KB))
  u_mpd_decoder_asserts (.ref_clk, .reset_n, .req, .prog_mode, .cfg_a_we,
  .cfg_b_we, .cfg_wdata, .flash_move_write_enable, .pflash_protect,
  .sfr_implemented, .sfr_erase, .hw_config_reg_a, .hw_config_reg_b,
  .route, .sfr_read_zero);
